//--- common/framer_pkg.sv
// Constants for the packet framer and hop sequencer.
// Assumes a 100 MHz system clock and an 8-bit register port.
`default_nettype none

package framer_pkg;

  // ==========================================================
  // Clock
  localparam int unsigned CLK_HZ = 100_000_000;

  // ==========================================================
  // Register offsets
  localparam logic [3:0] PREAMBLE_COUNT_HIGH_ADDR  = 4'h0;
  localparam logic [3:0] PREAMBLE_COUNT_LOW_ADDR   = 4'h1;
  localparam logic [3:0] MODEM_CONFIG_FIRST_ADDR   = 4'h2;
  localparam logic [3:0] MODEM_CONFIG_SECOND_ADDR  = 4'h3;
  localparam logic [3:0] PAYLOAD_LENGTH_ADDR       = 4'h4;
  localparam logic [3:0] HOP_DWELL_REGISTER_ADDR   = 4'h5;
  localparam logic [3:0] HOP_CHANNEL_REGISTER_ADDR = 4'h6;
  localparam logic [3:0] IRQ_FLAGS_ADDR            = 4'h7;
  localparam logic [3:0] FRAME_CONTROL_ADDR        = 4'h8;
  localparam logic [3:0] FRAME_STATUS_ADDR         = 4'h9;
  localparam logic [3:0] PAYLOAD_SYMS_HIGH_ADDR    = 4'hA;
  localparam logic [3:0] PAYLOAD_SYMS_LOW_ADDR     = 4'hB;

  // ==========================================================
  // Field positions
  localparam int HEADERLESS_BIT  = 0;
  localparam int CR_LSB          = 1;
  localparam int CRC_ON_BIT      = 4;
  localparam int SLOW_RATE_BIT   = 5;
  localparam int SF_LSB          = 0;
  localparam int BW_LSB          = 4;
  localparam int HOP_FLAG_BIT    = 0;
  localparam int TX_START_BIT    = 0;
  localparam int RX_START_BIT    = 1;

  // ==========================================================
  // Reset values
  localparam logic [7:0] PREAMBLE_HIGH_RST = 8'h00;
  localparam logic [7:0] PREAMBLE_LOW_RST  = 8'h0C;
  localparam logic [7:0] CONFIG_FIRST_RST  = 8'h02;
  localparam logic [7:0] CONFIG_SECOND_RST = 8'h77;
  localparam logic [7:0] PAYLOAD_LEN_RST   = 8'h01;
  localparam logic [7:0] HOP_DWELL_RST     = 8'h00;

  // ==========================================================
  // Framing figures
  localparam logic [15:0] PREAMBLE_MIN    = 16'h0006;
  localparam logic [16:0] PREAMBLE_FIXED  = 17'h00004;
  localparam int          HEADER_SYMS     = 8;
  localparam logic [2:0]  HEADER_CR       = 3'h4;
  localparam logic [3:0]  SF_MIN          = 4'h6;
  localparam logic [3:0]  SF_MAX          = 4'hC;
  localparam logic [3:0]  BW_LAST         = 4'h9;

  // Bandwidths in tenths of a hertz, codes 0 to 9
  localparam int unsigned BW_DHZ [10] = '{78000, 104000, 156000, 208000,
    312000, 417000, 625000, 1250000, 2500000, 5000000};

endpackage : framer_pkg

`default_nettype wire

//--- src/spread_packet_framer_hopper.sv
// Packet framer and hop sequencer: timing of preamble, header, payload
// and channel hops. Assumes the modem datapath signals preamble
// detection and header outcome on the system clock.
`timescale 1ns/1ps
`default_nettype none

module spread_packet_framer_hopper
  import framer_pkg::*;
#(
  parameter int unsigned CLK_RATE_HZ = framer_pkg::CLK_HZ
)(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       preamble_found,
  input  wire logic       header_ok,
  input  wire logic       header_crc_bad,
  input  wire logic [7:0] header_length,
  input  wire logic [2:0] header_rate,
  input  wire logic       header_crc_on,
  output logic      [5:0] current_hop_index,
  output logic            hop_change_irq,
  output logic      [2:0] coding_rate,
  output logic            crc_append,
  output logic            preamble_active,
  output logic            header_active,
  output logic            frame_done
);

  // ==========================================================
  // Declarations
  typedef enum logic [4:0] {
    S_IDLE   = 5'b00001,
    S_SEARCH = 5'b00010,
    S_PRE    = 5'b00100,
    S_QTR    = 5'b01000,
    S_BODY   = 5'b10000
  } phase_e;

  phase_e      phase_reg;
  logic [7:0]  preamble_count_high_reg;
  logic [7:0]  preamble_count_low_reg;
  logic [7:0]  modem_config_first_reg;
  logic [7:0]  modem_config_second_reg;
  logic [7:0]  payload_length_reg;
  logic [7:0]  hop_dwell_register_reg;
  logic        hop_change_irq_flag_reg;
  logic        rx_mode_reg;
  logic [7:0]  eff_len_reg;
  logic [2:0]  eff_cr_reg;
  logic        eff_crc_reg;
  logic [31:0] cyc_cnt_reg;
  logic [12:0] chip_cnt_reg;
  logic [16:0] sym_left_reg;
  logic [15:0] body_idx_reg;
  logic [7:0]  dwell_cnt_reg;
  logic        headerless_framing_bit;
  logic        slow_rate_robust_bit;
  logic [3:0]  sf;
  logic [3:0]  bw;
  logic [15:0] preamble_symbol_count;
  logic [31:0] chip_cyc;
  logic [12:0] sym_chips;
  logic        chip_tick;
  logic        sym_tick;
  logic [15:0] payload_syms;
  logic        in_header;
  logic        hop_now;
  logic        tx_go;
  logic        rx_go;
  logic        flag_clr;

  assign headerless_framing_bit = modem_config_first_reg[HEADERLESS_BIT];
  assign slow_rate_robust_bit   = modem_config_first_reg[SLOW_RATE_BIT];
  assign tx_go    = reg_wr && (reg_addr == FRAME_CONTROL_ADDR)
                    && reg_wdata[TX_START_BIT];
  assign rx_go    = reg_wr && (reg_addr == FRAME_CONTROL_ADDR)
                    && reg_wdata[RX_START_BIT];
  assign flag_clr = reg_wr && (reg_addr == IRQ_FLAGS_ADDR)
                    && reg_wdata[HOP_FLAG_BIT];

  // ==========================================================
  // Configuration registers
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      preamble_count_high_reg <= PREAMBLE_HIGH_RST;
      preamble_count_low_reg  <= PREAMBLE_LOW_RST;
      modem_config_first_reg  <= CONFIG_FIRST_RST;
      modem_config_second_reg <= CONFIG_SECOND_RST;
      payload_length_reg      <= PAYLOAD_LEN_RST;
      hop_dwell_register_reg  <= HOP_DWELL_RST;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        PREAMBLE_COUNT_HIGH_ADDR: preamble_count_high_reg <= reg_wdata;
        PREAMBLE_COUNT_LOW_ADDR:  preamble_count_low_reg  <= reg_wdata;
        MODEM_CONFIG_FIRST_ADDR:  modem_config_first_reg  <= reg_wdata;
        MODEM_CONFIG_SECOND_ADDR: modem_config_second_reg <= reg_wdata;
        PAYLOAD_LENGTH_ADDR:      payload_length_reg      <= reg_wdata;
        HOP_DWELL_REGISTER_ADDR:  hop_dwell_register_reg  <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Derived framing figures
  always_comb
  begin
    logic [15:0] raw;
    raw = {preamble_count_high_reg, preamble_count_low_reg};
    preamble_symbol_count = (raw < PREAMBLE_MIN) ? PREAMBLE_MIN : raw;
    sf = modem_config_second_reg[SF_LSB +: 4];
    if (sf < SF_MIN)
      sf = SF_MIN;
    else if (sf > SF_MAX)
      sf = SF_MAX;
    bw = modem_config_second_reg[BW_LSB +: 4];
    if (bw > BW_LAST)
      bw = BW_LAST;
  end

  // Chip period from bandwidth; symbol is 2^SF chips, 2^(SF-2) chips in S_QTR
  assign chip_cyc  = 32'((64'(CLK_RATE_HZ) * 64'd10)
                     / 64'(BW_DHZ[bw]));
  assign sym_chips = (phase_reg == S_QTR) ? 13'(13'h1 << (sf - 4'h2))
                                          : 13'(13'h1 << sf);
  assign chip_tick = (cyc_cnt_reg + 32'h1 >= chip_cyc);
  assign sym_tick  = chip_tick && (chip_cnt_reg + 13'h1 == sym_chips);

  // Payload symbol count, header symbols included
  always_comb
  begin
    int num;
    int den;
    int blk;
    num = 8 * int'(eff_len_reg) - 4 * int'(sf) + 28 + 16
          - 20 * int'(headerless_framing_bit);
    den = 4 * (int'(sf) - 2 * int'(slow_rate_robust_bit));
    blk = (num > 0) ? (num + den - 1) / den : 0;
    payload_syms = 16'(8 + blk * (int'(eff_cr_reg) + 4));
  end

  assign in_header = !headerless_framing_bit
                     && (body_idx_reg < 16'(HEADER_SYMS));
  assign hop_now   = (phase_reg == S_BODY) && !in_header && sym_tick
                     && (hop_dwell_register_reg != 8'h00)
                     && (dwell_cnt_reg + 8'h1 == hop_dwell_register_reg);

  // ==========================================================
  // Symbol timing
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cyc_cnt_reg  <= 32'h0;
      chip_cnt_reg <= 13'h0;
    end
    else if (phase_reg == S_IDLE || phase_reg == S_SEARCH || tx_go
             || rx_go || preamble_found)
    begin
      cyc_cnt_reg  <= 32'h0;
      chip_cnt_reg <= 13'h0;
    end
    else if (chip_tick)
    begin
      cyc_cnt_reg  <= 32'h0;
      chip_cnt_reg <= sym_tick ? 13'h0 : chip_cnt_reg + 13'h1;
    end
    else
      cyc_cnt_reg <= cyc_cnt_reg + 32'h1;
  end

  // ==========================================================
  // Frame sequencer
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      phase_reg    <= S_IDLE;
      rx_mode_reg  <= 1'b0;
      sym_left_reg <= 17'h0;
      body_idx_reg <= 16'h0;
    end
    else if (tx_go)
    begin
      phase_reg    <= S_PRE;
      rx_mode_reg  <= 1'b0;
      sym_left_reg <= {1'b0, preamble_symbol_count} + PREAMBLE_FIXED;
    end
    else if (rx_go)
    begin
      phase_reg   <= S_SEARCH;
      rx_mode_reg <= 1'b1;
    end
    else
    begin
      case (phase_reg)
        S_SEARCH:
          if (preamble_found)
          begin
            phase_reg    <= S_BODY;
            body_idx_reg <= 16'h0;
          end
        S_PRE:
          if (sym_tick)
          begin
            sym_left_reg <= sym_left_reg - 17'h1;
            if (sym_left_reg == 17'h1)
              phase_reg <= S_QTR;
          end
        S_QTR:
          if (sym_tick)
          begin
            phase_reg    <= S_BODY;
            body_idx_reg <= 16'h0;
          end
        S_BODY:
          if (rx_mode_reg && in_header && header_crc_bad)
            phase_reg <= S_SEARCH;
          else if (sym_tick)
          begin
            body_idx_reg <= body_idx_reg + 16'h1;
            if (body_idx_reg + 16'h1 >= payload_syms)
              phase_reg <= rx_mode_reg ? S_SEARCH : S_IDLE;
          end
        S_IDLE: ;
        default: phase_reg <= S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Payload fields: registers, or received header when explicit
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      eff_len_reg <= PAYLOAD_LEN_RST;
      eff_cr_reg  <= CONFIG_FIRST_RST[CR_LSB +: 3];
      eff_crc_reg <= 1'b0;
    end
    else if (tx_go || rx_go || preamble_found || phase_reg == S_IDLE)
    begin
      eff_len_reg <= payload_length_reg;
      eff_cr_reg  <= modem_config_first_reg[CR_LSB +: 3];
      eff_crc_reg <= modem_config_first_reg[CRC_ON_BIT];
    end
    else if (rx_mode_reg && header_ok && in_header
             && phase_reg == S_BODY)
    begin
      eff_len_reg <= header_length;
      eff_cr_reg  <= header_rate;
      eff_crc_reg <= header_crc_on;
    end
  end

  // ==========================================================
  // Hop channel and change flag
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dwell_cnt_reg     <= 8'h0;
      current_hop_index <= 6'h0;
      hop_change_irq    <= 1'b0;
    end
    else
    begin
      hop_change_irq <= hop_now;
      if (tx_go || rx_go || phase_reg == S_SEARCH)
      begin
        dwell_cnt_reg     <= 8'h0;
        current_hop_index <= 6'h0;
      end
      else if (hop_now)
      begin
        dwell_cnt_reg     <= 8'h0;
        current_hop_index <= current_hop_index + 6'h1;
      end
      else if (phase_reg == S_BODY && !in_header && sym_tick)
        dwell_cnt_reg <= dwell_cnt_reg + 8'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      hop_change_irq_flag_reg <= 1'b0;
    else if (hop_now)
      hop_change_irq_flag_reg <= 1'b1;
    else if (flag_clr)
      hop_change_irq_flag_reg <= 1'b0;
  end

  // ==========================================================
  // Frame outputs
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      coding_rate     <= HEADER_CR;
      crc_append      <= 1'b0;
      preamble_active <= 1'b0;
      header_active   <= 1'b0;
      frame_done      <= 1'b0;
    end
    else
    begin
      coding_rate     <= (phase_reg == S_BODY && in_header)
                         ? HEADER_CR : eff_cr_reg;
      crc_append      <= eff_crc_reg;
      preamble_active <= (phase_reg == S_PRE) || (phase_reg == S_QTR);
      header_active   <= (phase_reg == S_BODY) && in_header;
      frame_done      <= (phase_reg == S_BODY) && sym_tick
                         && (body_idx_reg + 16'h1 >= payload_syms);
    end
  end

  // ==========================================================
  // Register reads, data in the following cycle only
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      reg_rdata <= 8'h00;
    else if (!reg_rd)
      reg_rdata <= 8'h00;
    else
    begin
      case (reg_addr)
        PREAMBLE_COUNT_HIGH_ADDR:  reg_rdata <= preamble_count_high_reg;
        PREAMBLE_COUNT_LOW_ADDR:   reg_rdata <= preamble_count_low_reg;
        MODEM_CONFIG_FIRST_ADDR:   reg_rdata <= modem_config_first_reg;
        MODEM_CONFIG_SECOND_ADDR:  reg_rdata <= modem_config_second_reg;
        PAYLOAD_LENGTH_ADDR:       reg_rdata <= payload_length_reg;
        HOP_DWELL_REGISTER_ADDR:   reg_rdata <= hop_dwell_register_reg;
        HOP_CHANNEL_REGISTER_ADDR: reg_rdata <= {2'b00, current_hop_index};
        IRQ_FLAGS_ADDR:    reg_rdata <= {7'h00, hop_change_irq_flag_reg};
        FRAME_STATUS_ADDR: reg_rdata <= {3'h0, phase_reg};
        PAYLOAD_SYMS_HIGH_ADDR:    reg_rdata <= payload_syms[15:8];
        PAYLOAD_SYMS_LOW_ADDR:     reg_rdata <= payload_syms[7:0];
        default:                   reg_rdata <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Assertions
  property p_hop_irq_pulse;
    @(posedge clk) disable iff (!rst_b)
    hop_now |=> hop_change_irq && $changed(current_hop_index);
  endproperty
  a_hop_irq_pulse: assert property (p_hop_irq_pulse)
    else $error("hop irq not at channel change");

  property p_flag_set_wins;
    @(posedge clk) disable iff (!rst_b)
    hop_now && flag_clr |=> hop_change_irq_flag_reg;
  endproperty
  a_flag_set_wins: assert property (p_flag_set_wins)
    else $error("hop flag lost on clear");

  property p_no_hop_zero_dwell;
    @(posedge clk) disable iff (!rst_b)
    hop_dwell_register_reg == 8'h00 |=> !hop_change_irq;
  endproperty
  a_no_hop_zero_dwell: assert property (p_no_hop_zero_dwell)
    else $error("hop with zero dwell");

  property p_header_channel0;
    @(posedge clk) disable iff (!rst_b)
    header_active || preamble_active |-> current_hop_index == 6'h0;
  endproperty
  a_header_channel0: assert property (p_header_channel0)
    else $error("preamble or header off channel 0");

  property p_header_rate;
    @(posedge clk) disable iff (!rst_b)
    header_active |-> coding_rate == HEADER_CR;
  endproperty
  a_header_rate: assert property (p_header_rate)
    else $error("header not at strongest rate");

  property p_bad_header_restart;
    @(posedge clk) disable iff (!rst_b)
    rx_mode_reg && phase_reg == S_BODY && in_header && header_crc_bad
      && !tx_go && !rx_go
    |=> phase_reg == S_SEARCH ##1 current_hop_index == 6'h0;
  endproperty
  a_bad_header_restart: assert property (p_bad_header_restart)
    else $error("bad header did not restart search");

  property p_search_on_channel0;
    @(posedge clk) disable iff (!rst_b)
    phase_reg == S_SEARCH |=> current_hop_index == 6'h0;
  endproperty
  a_search_on_channel0: assert property (p_search_on_channel0)
    else $error("search not on channel 0");

  property p_preamble_load;
    @(posedge clk) disable iff (!rst_b)
    tx_go |=> sym_left_reg == {1'b0, $past(preamble_symbol_count)}
      + PREAMBLE_FIXED;
  endproperty
  a_preamble_load: assert property (p_preamble_load)
    else $error("preamble length wrong");

  property p_no_header_implicit;
    @(posedge clk) disable iff (!rst_b)
    headerless_framing_bit |=> !header_active;
  endproperty
  a_no_header_implicit: assert property (p_no_header_implicit)
    else $error("header sent in implicit framing");

endmodule : spread_packet_framer_hopper

`default_nettype wire

//--- tb/demod_model.sv
// Demodulator stand-in: reports preamble detection and header outcome.
// Assumes a one-cycle go request from the testbench, all on clk.
`timescale 1ns/1ps
`default_nettype none

module demod_model #(
  parameter int PRE_WAIT = 40,
  parameter int HDR_WAIT = 500
)(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       go,
  input  wire logic       bad,
  input  wire logic [7:0] hdr_len,
  input  wire logic [2:0] hdr_rate,
  input  wire logic       hdr_crc,
  output logic            preamble_found,
  output logic            header_ok,
  output logic            header_crc_bad,
  output logic      [7:0] header_length,
  output logic      [2:0] header_rate,
  output logic            header_crc_on
);
  int         cnt;
  logic       busy;
  logic [7:0] pat;

  // ==========================================================
  // Detection sequence
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt            <= 0;
      busy           <= 1'b0;
      pat            <= 8'h00;
      preamble_found <= 1'b0;
      header_ok      <= 1'b0;
      header_crc_bad <= 1'b0;
    end
    else
    begin
      pat            <= pat + 8'h01;
      preamble_found <= 1'b0;
      header_ok      <= 1'b0;
      header_crc_bad <= 1'b0;
      if (go)
      begin
        busy <= 1'b1;
        cnt  <= 0;
      end
      else if (busy)
      begin
        cnt <= cnt + 1;
        if (cnt == PRE_WAIT)
          preamble_found <= 1'b1;
        if (cnt == PRE_WAIT + HDR_WAIT)
        begin
          header_ok      <= !bad;
          header_crc_bad <= bad;
          busy           <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Header fields, valid only beside header_ok
  assign header_length = header_ok ? hdr_len : pat;
  assign header_rate   = header_ok ? hdr_rate : pat[2:0];
  assign header_crc_on = header_ok ? hdr_crc : pat[0];

endmodule : demod_model
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the packet framer and hop sequencer.
// Assumes framer_pkg and a 500 kHz rate setting: one chip per cycle.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import framer_pkg::*;
  localparam int unsigned RATE = 500000;
  localparam int          SYM  = 128;
  localparam logic [7:0]  RST_TAB [6] = '{PREAMBLE_HIGH_RST,
    PREAMBLE_LOW_RST, CONFIG_FIRST_RST, CONFIG_SECOND_RST,
    PAYLOAD_LEN_RST, HOP_DWELL_RST};

  logic       clk, rst_b, reg_wr, reg_rd, go, bad, hdr_crc, rd_d, hdr_skip;
  logic       preamble_found, header_ok, header_crc_bad, header_crc_on;
  logic       hop_change_irq, crc_append, preamble_active, header_active;
  logic       frame_done;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, hdr_len, header_length;
  logic [2:0] hdr_rate, header_rate, coding_rate;
  logic [5:0] current_hop_index;
  int         bad_count, num_checks, seed, i, k, n, pl, sf, h, de, cr;
  int         pre_cnt, hdr_cnt;
  logic [7:0] rd_q [$];
  logic [5:0] hop_q [$];
  int         len_q [$];
  logic [3:0] pay_q [$];

  spread_packet_framer_hopper #(.CLK_RATE_HZ(RATE)) dut (.clk(clk),
    .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .preamble_found(preamble_found), .header_ok(header_ok),
    .header_crc_bad(header_crc_bad), .header_length(header_length),
    .header_rate(header_rate), .header_crc_on(header_crc_on),
    .current_hop_index(current_hop_index),
    .hop_change_irq(hop_change_irq), .coding_rate(coding_rate),
    .crc_append(crc_append), .preamble_active(preamble_active),
    .header_active(header_active), .frame_done(frame_done));

  demod_model #(.PRE_WAIT(40), .HDR_WAIT(500)) partner (.clk(clk),
    .rst_b(rst_b), .go(go), .bad(bad), .hdr_len(hdr_len),
    .hdr_rate(hdr_rate), .hdr_crc(hdr_crc),
    .preamble_found(preamble_found), .header_ok(header_ok),
    .header_crc_bad(header_crc_bad), .header_length(header_length),
    .header_rate(header_rate), .header_crc_on(header_crc_on));

  always #5 clk = ~clk;

  // ==========================================================
  // Reporting and comparison
  task close_out;
    if (rd_q.size() + hop_q.size() + len_q.size() + pay_q.size() != 0)
      bad_count++;
    if (bad_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out

  task bad_line(input logic [31:0] g, input logic [31:0] e);
    bad_count++;
    $display("BAD t=%0t got=%h exp=%h", $time, g, e);
  endtask : bad_line

  task cmp_rd(input logic [7:0] g);
    logic [7:0] e;
    num_checks++;
    e = (rd_q.size() != 0) ? rd_q.pop_front() : 8'hXX;
    if (g !== e) bad_line(g, e);
  endtask : cmp_rd

  task cmp_hop(input logic [5:0] g);
    logic [5:0] e;
    num_checks++;
    e = (hop_q.size() != 0) ? hop_q.pop_front() : 6'hXX;
    if (g !== e) bad_line(g, e);
  endtask : cmp_hop

  task cmp_pay(input logic [3:0] g);
    logic [3:0] e;
    num_checks++;
    e = (pay_q.size() != 0) ? pay_q.pop_front() : 4'hX;
    if (g !== e) bad_line(g, e);
  endtask : cmp_pay

  task cmp_len(input int g);
    int e;
    num_checks++;
    e = (len_q.size() != 0) ? len_q.pop_front() : -1;
    if (g != e) bad_line(g, e);
  endtask : cmp_len

  task cmp_now(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) bad_line(g, e);
  endtask : cmp_now

  // ==========================================================
  // Result watcher
  always @(posedge clk)
  begin
    if (rst_b)
    begin
      if (rd_d)
        cmp_rd(reg_rdata);
      else
        cmp_now(reg_rdata, 8'h00);
      if (hop_change_irq) cmp_hop(current_hop_index);
      if (frame_done) cmp_pay({crc_append, coding_rate});
      if (preamble_active)
      begin
        pre_cnt++;
        cmp_now({2'h0, current_hop_index}, 8'h00);
      end
      else if (pre_cnt != 0)
      begin
        cmp_len(pre_cnt);
        pre_cnt = 0;
      end
      if (header_active)
      begin
        hdr_cnt++;
        cmp_now({5'h00, coding_rate}, {5'h00, HEADER_CR});
      end
      else if (hdr_cnt != 0)
      begin
        if (!hdr_skip) cmp_len(hdr_cnt);
        hdr_cnt = 0;
      end
    end
    rd_d <= reg_rd;
  end

  // ==========================================================
  // Bus and frame tasks
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    rd_q.push_back(e);
    @(posedge clk);
    reg_rd   <= 1'b0;
  endtask : rd

  task wait_done;
    for (k = 0; k < 20000 && frame_done !== 1'b1; k++) @(posedge clk);
    if (k == 20000) begin bad_count++; close_out(); end
  endtask : wait_done

  task pulse_go;
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask : pulse_go

  function automatic int syms(input int pl, sf, h, de, cr);
    int num, den;
    num = 8 * pl - 4 * sf + 28 + 16 - 20 * h;
    den = 4 * (sf - 2 * de);
    return 8 + ((num > 0) ? (num + den - 1) / den : 0) * (cr + 4);
  endfunction : syms

  task tx_frame(input int pre_n, hdr, cr, crc);
    int ps, j;
    ps = syms(10, 7, hdr ? 0 : 1, 0, cr);
    len_q.push_back((pre_n + 4) * SYM + SYM / 4);
    if (hdr) len_q.push_back(HEADER_SYMS * SYM);
    for (j = 1; j <= (ps - 8 * hdr - 1) / 3; j++) hop_q.push_back(j[5:0]);
    pay_q.push_back({crc[0], cr[2:0]});
    wr(MODEM_CONFIG_FIRST_ADDR, {3'h0, crc[0], cr[2:0], ~hdr[0]});
    wr(FRAME_CONTROL_ADDR, 8'h01);
    wait_done();
  endtask : tx_frame

  // ==========================================================
  // Main sequence
  initial
  begin
    clk = 0; rst_b = 0; reg_wr = 0; reg_rd = 0; reg_addr = 0;
    reg_wdata = 0; go = 0; bad = 0; hdr_len = 0; hdr_rate = 0;
    hdr_crc = 0; hdr_skip = 0; rd_d = 0; pre_cnt = 0; hdr_cnt = 0;
    bad_count = 0; num_checks = 0; seed = 32;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    for (i = 0; i < 6; i++) rd(i[3:0], RST_TAB[i]);
    rd(4'hF, 8'h00);
    wr(HOP_CHANNEL_REGISTER_ADDR, 8'h3F);
    rd(HOP_CHANNEL_REGISTER_ADDR, 8'h00);
    for (i = 0; i < 8; i++)
    begin
      pl = $random(seed) & 255;
      sf = 6 + {$random(seed)} % 7;
      h  = (sf == 6) ? 1 : $random(seed) & 1;
      de = $random(seed) & 1;
      cr = i % 4 + 1;
      wr(MODEM_CONFIG_SECOND_ADDR, {4'h9, sf[3:0]});
      wr(MODEM_CONFIG_FIRST_ADDR, {2'h0, de[0], 1'b0, cr[2:0], h[0]});
      wr(PAYLOAD_LENGTH_ADDR, pl[7:0]);
      n = syms(pl, sf, h, de, cr);
      rd(PAYLOAD_SYMS_HIGH_ADDR, n[15:8]);
      rd(PAYLOAD_SYMS_LOW_ADDR, n[7:0]);
    end
    wr(MODEM_CONFIG_SECOND_ADDR, 8'h97);
    wr(PAYLOAD_LENGTH_ADDR, 8'h0A);
    wr(HOP_DWELL_REGISTER_ADDR, 8'h03);
    tx_frame(12, 1, 1, 1);
    rd(HOP_CHANNEL_REGISTER_ADDR, 8'h06);
    rd(IRQ_FLAGS_ADDR, 8'h01);
    wr(IRQ_FLAGS_ADDR, 8'h01);
    rd(IRQ_FLAGS_ADDR, 8'h00);
    wr(PREAMBLE_COUNT_LOW_ADDR, 8'h03);
    tx_frame(6, 0, 2, 0);
    wr(HOP_DWELL_REGISTER_ADDR, 8'h00);
    wr(MODEM_CONFIG_FIRST_ADDR, 8'h12);
    hdr_skip <= 1'b1;
    hdr_len  <= 8'h0A;
    hdr_rate <= 3'h3;
    hdr_crc  <= 1'b1;
    pay_q.push_back(4'hB);
    wr(PREAMBLE_COUNT_LOW_ADDR, 8'h06);
    wr(FRAME_CONTROL_ADDR, 8'h02);
    rd(FRAME_STATUS_ADDR, 8'h02);
    pulse_go();
    wait_done();
    rd(FRAME_STATUS_ADDR, 8'h02);
    wr(HOP_DWELL_REGISTER_ADDR, 8'h03);
    bad <= 1'b1;
    pulse_go();
    for (k = 0; k < 2000 && header_crc_bad !== 1'b1; k++) @(posedge clk);
    if (k == 2000) begin bad_count++; close_out(); end
    rd(FRAME_STATUS_ADDR, 8'h02);
    rd(HOP_CHANNEL_REGISTER_ADDR, 8'h00);
    repeat (4) @(posedge clk);
    close_out();
  end

endmodule : testbench
`default_nettype wire
